// *** hw/i2c_port_params.svh ***
// Constants for the two-wire register port: addresses, offsets, reset values.
// Assumes inclusion by bare name from the design files of this block.
`ifndef I2C_PORT_PARAMS_SVH
`define I2C_PORT_PARAMS_SVH

// ----------------------------------------------------------------------
// Bus addressing
// ----------------------------------------------------------------------
`define DEV_ADDR          7'h43
`define BYTE_BITS         4'h8

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_REVISION      8'h00
`define OFS_IDENTIFIER    8'h01
`define OFS_SYNTH_LOW     8'h05
`define OFS_SYNTH_MULT    8'h06
`define OFS_SYNTH_DIV     8'h07
`define OFS_REQUEST_LINE_POLARITY       8'h0c
`define OFS_CLK_POL       8'h0d
`define OFS_FAULT         8'h0f
`define OFS_RESTART       8'h10
`define OFS_PLAYBACK      8'h13
`define OFS_SILENCE       8'h14
`define OFS_CMD_IRQ       8'h16
`define OFS_REQ_EN        8'h18
`define OFS_LOCK          8'h40
`define OFS_AUX_LOW       8'h41
`define OFS_AUX_HIGH      8'h42
`define OFS_HDR_HIGH      8'h43
`define OFS_HDR_MID       8'h44

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_SYNTH_LOW     8'ha1
`define RST_SYNTH_MULT    8'h0c
`define RST_SYNTH_DIV     8'h00
`define RST_REQUEST_LINE_POLARITY       8'h01
`define RST_CLK_POL       8'h04
`define RST_PLAYBACK      8'h01
`define RST_SILENCE       8'h00
`define RST_CMD_IRQ       8'h00
`define RST_REQ_EN        8'h00

`endif

// *** hw/i2c_port_pkg.sv ***
// Types shared by the two-wire register port.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package i2c_port_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_SUB, ST_SUB_ACK,
    ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK, ST_IGNORE
  } port_state_t;
endpackage
`default_nettype wire

// *** hw/two_wire_front.sv ***
// Edge and bus-condition detector for the clock and data lines.
// Assumes both lines are already synchronous to clk.
`default_nettype none
module two_wire_front (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  // Bus lines
  input  wire logic scl_i,
  input  wire logic sda_i,
  // Events, one-cycle pulses
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start_det,
  output logic      stop_det
);
  logic scl_q;
  logic sda_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else if (ce)
    begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  assign scl_rise  = ce & scl_i & ~scl_q;
  assign scl_fall  = ce & ~scl_i & scl_q;
  assign start_det = ce & scl_i & scl_q & sda_q & ~sda_i;
  assign stop_det  = ce & scl_i & scl_q & ~sda_q & sda_i;
endmodule
`default_nettype wire

// *** hw/reg_bank.sv ***
// Eight-bit register file behind the two-wire port.
// Assumes one write pulse per byte and a read address held by the caller.
`default_nettype none
`include "i2c_port_params.svh"
module reg_bank #(
  parameter logic [7:0] REVISION   = 8'h5a,
  // Arbitrary value, not tied to any real part.
  parameter logic [7:0] IDENTIFIER = 8'h3c
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // Access port
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic [7:0] rd_addr,
  output logic      [7:0] rd_data,
  // Status from the decoder
  input  wire logic [7:0] fault_code,
  input  wire logic [7:0] frame_lock_state,
  input  wire logic [7:0] aux_byte_count_low,
  input  wire logic [7:0] aux_byte_count_high,
  input  wire logic [7:0] frame_header_high,
  input  wire logic [7:0] frame_header_middle,
  // Control registers
  output logic      [7:0] ctrl_q [9],
  output logic            software_restart_q
);
  localparam int NRW = 9;
  localparam logic [7:0] RW_OFS [NRW] = '{`OFS_SYNTH_LOW, `OFS_SYNTH_MULT,
    `OFS_SYNTH_DIV, `OFS_REQUEST_LINE_POLARITY, `OFS_CLK_POL, `OFS_PLAYBACK,
    `OFS_SILENCE, `OFS_CMD_IRQ, `OFS_REQ_EN};
  localparam logic [7:0] RW_RST [NRW] = '{`RST_SYNTH_LOW, `RST_SYNTH_MULT,
    `RST_SYNTH_DIV, `RST_REQUEST_LINE_POLARITY, `RST_CLK_POL, `RST_PLAYBACK,
    `RST_SILENCE, `RST_CMD_IRQ, `RST_REQ_EN};

  // Returns {hit, index} of a writable register.
  function automatic logic [4:0] rw_decode(input logic [7:0] a);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < NRW; i++)
      if (a == RW_OFS[i])
        r = {1'b1, i[3:0]};
    return r;
  endfunction

  wire logic [4:0] wr_dec = rw_decode(wr_addr);
  wire logic [4:0] rd_dec = rw_decode(rd_addr);

  for (genvar g = 0; g < NRW; g++)
  begin : g_rw
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
        ctrl_q[g] <= RW_RST[g];
      else if (ce && wr_en && wr_dec[4] && wr_dec[3:0] == 4'(g))
        ctrl_q[g] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      software_restart_q <= 1'b0;
    else if (ce)
      software_restart_q <= wr_en && wr_addr == `OFS_RESTART;
  end

  // Writes to read-only or unmapped offsets are dropped; unmapped reads give zero.
  always_comb
  begin
    rd_data = 8'h00;
    if (rd_dec[4])
      rd_data = ctrl_q[rd_dec[3:0]];
    else
      case (rd_addr)
        `OFS_REVISION:   rd_data = REVISION;
        `OFS_IDENTIFIER: rd_data = IDENTIFIER;
        `OFS_FAULT:      rd_data = fault_code;
        `OFS_LOCK:       rd_data = frame_lock_state;
        `OFS_AUX_LOW:    rd_data = aux_byte_count_low;
        `OFS_AUX_HIGH:   rd_data = aux_byte_count_high;
        `OFS_HDR_HIGH:   rd_data = frame_header_high;
        `OFS_HDR_MID:    rd_data = frame_header_middle;
        default:         rd_data = 8'h00;
      endcase
  end
endmodule
`default_nettype wire

// *** hw/i2c_slave_register_port.sv ***
// Two-wire slave port giving an external master access to the register file.
// Assumes bus lines synchronous to clk and an external open-drain pad.
//
// Functional notes
// - Port is slave only: never drives clock, never starts a transfer.
// - Start is data falling with clock high; it precedes every transfer.
// - Stop is data rising with clock high; device returns to idle.
// - After eight bits the receiver pulls data low on the ninth pulse.
// - Device samples data on the rising clock edge when receiving.
// - First byte is MSB first; upper seven bits compared with 1000011.
// - Address LSB chooses read (1) or write (0); ack only on match.
// - Byte after write address loads the pointer and is acknowledged.
// - Each later write byte is stored at the pointer and acknowledged.
// - Pointer increments by one after every byte written or read.
// - Read address acknowledged, then the pointed register shifts out.
// - Master ack asks the next register; master nack then stop ends reads.
// - Registers without reset value are undefined after reset.
`default_nettype none
`include "i2c_port_params.svh"
module i2c_slave_register_port #(
  parameter logic [6:0] DEV_ADDR   = `DEV_ADDR,
  parameter int         PTR_W      = 8,
  parameter logic [7:0] REVISION   = 8'h5a,
  // Arbitrary value, not tied to any real part.
  parameter logic [7:0] IDENTIFIER = 8'h3c
) (
  // Clock, reset, enable
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // Two-wire bus (data is open drain)
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  // Status from the decoder
  input  wire logic [7:0] fault_code,
  input  wire logic [7:0] frame_lock_state,
  input  wire logic [7:0] aux_byte_count_low,
  input  wire logic [7:0] aux_byte_count_high,
  input  wire logic [7:0] frame_header_high,
  input  wire logic [7:0] frame_header_middle,
  // Control registers
  output logic      [7:0] clock_synth_control_low,
  output logic      [7:0] clock_synth_multiplier,
  output logic      [7:0] clock_synth_input_divider,
  output logic      [7:0] request_line_polarity,
  output logic      [7:0] input_clock_polarity,
  output logic      [7:0] playback_control,
  output logic      [7:0] output_silence,
  output logic      [7:0] command_irq,
  output logic      [7:0] request_line_enable,
  output logic            software_restart
);
  if (PTR_W != 8)
  begin : g_chk
    $error("Pointer width must be eight bits");
  end

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic [1:0] rst_sync_q;
  wire logic  rst_sync_n = rst_sync_q[1];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  // ----------------------------------------------------------------------
  // Bus events
  // ----------------------------------------------------------------------
  wire logic scl_rise;
  wire logic scl_fall;
  wire logic start_det;
  wire logic stop_det;

  two_wire_front u_front (
    .clk       (clk),
    .rst_n     (rst_sync_n),
    .ce        (ce),
    .scl_i     (scl_i),
    .sda_i     (sda_i),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det)
  );

  // ----------------------------------------------------------------------
  // Protocol state
  // ----------------------------------------------------------------------
  i2c_port_pkg::port_state_t state_q;
  i2c_port_pkg::port_state_t state_d;
  logic [3:0]       cnt_q;
  logic [3:0]       cnt_d;
  logic [7:0]       sh_q;
  logic [7:0]       sh_d;
  logic [7:0]       tx_q;
  logic [7:0]       tx_d;
  logic [PTR_W-1:0] ptr_q;
  logic [PTR_W-1:0] ptr_d;
  logic             oe_q;
  logic             oe_d;
  logic             rw_q;
  logic             rw_d;
  logic             mack_q;
  logic             mack_d;
  logic             wr_en_q;
  logic             wr_en_d;
  logic [7:0]       wr_addr_q;
  logic [7:0]       wr_addr_d;
  logic [7:0]       wr_data_q;
  logic [7:0]       wr_data_d;
  logic             sda_o_q;
  wire logic [7:0]  rd_data;
  wire logic        addr_hit  = sh_q[7:1] == DEV_ADDR;
  wire logic        byte_done = scl_fall && cnt_q == `BYTE_BITS;
  logic [7:0]       ctrl [9];

  always_comb
  begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    sh_d      = sh_q;
    tx_d      = tx_q;
    ptr_d     = ptr_q;
    oe_d      = oe_q;
    rw_d      = rw_q;
    mack_d    = mack_q;
    wr_en_d   = 1'b0;
    wr_addr_d = wr_addr_q;
    wr_data_d = wr_data_q;
    if (stop_det)
    begin
      state_d = i2c_port_pkg::ST_IDLE;
      oe_d    = 1'b0;
    end
    else if (start_det)
    begin
      state_d = i2c_port_pkg::ST_ADDR;
      cnt_d   = 4'h0;
      oe_d    = 1'b0;
    end
    else
      case (state_q)
        i2c_port_pkg::ST_ADDR, i2c_port_pkg::ST_SUB, i2c_port_pkg::ST_WR:
        begin
          if (scl_rise)
          begin
            sh_d  = {sh_q[6:0], sda_i};
            cnt_d = cnt_q + 4'h1;
          end
          else if (byte_done)
          begin
            cnt_d = 4'h0;
            oe_d  = 1'b1;
            if (state_q == i2c_port_pkg::ST_ADDR)
            begin
              rw_d    = sh_q[0];
              state_d = addr_hit ? i2c_port_pkg::ST_ADDR_ACK : i2c_port_pkg::ST_IGNORE;
              oe_d    = addr_hit;
            end
            else if (state_q == i2c_port_pkg::ST_SUB)
            begin
              ptr_d   = sh_q;
              state_d = i2c_port_pkg::ST_SUB_ACK;
            end
            else
            begin
              wr_en_d   = 1'b1;
              wr_addr_d = ptr_q;
              wr_data_d = sh_q;
              ptr_d     = ptr_q + 8'h01;
              state_d   = i2c_port_pkg::ST_WR_ACK;
            end
          end
        end
        i2c_port_pkg::ST_ADDR_ACK:
          if (scl_fall)
          begin
            cnt_d = 4'h0;
            if (rw_q)
            begin
              tx_d    = rd_data;
              oe_d    = ~rd_data[7];
              state_d = i2c_port_pkg::ST_RD;
            end
            else
            begin
              oe_d    = 1'b0;
              state_d = i2c_port_pkg::ST_SUB;
            end
          end
        i2c_port_pkg::ST_SUB_ACK, i2c_port_pkg::ST_WR_ACK:
          if (scl_fall)
          begin
            oe_d    = 1'b0;
            state_d = i2c_port_pkg::ST_WR;
          end
        i2c_port_pkg::ST_RD:
          if (scl_fall)
          begin
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == 4'h7)
            begin
              oe_d    = 1'b0;
              ptr_d   = ptr_q + 8'h01;
              state_d = i2c_port_pkg::ST_RD_ACK;
            end
            else
            begin
              tx_d = {tx_q[6:0], 1'b0};
              oe_d = ~tx_q[6];
            end
          end
        i2c_port_pkg::ST_RD_ACK:
          if (scl_rise)
            mack_d = ~sda_i;
          else if (scl_fall)
          begin
            cnt_d = 4'h0;
            if (mack_q)
            begin
              tx_d    = rd_data;
              oe_d    = ~rd_data[7];
              state_d = i2c_port_pkg::ST_RD;
            end
            else
              state_d = i2c_port_pkg::ST_IGNORE;
          end
        i2c_port_pkg::ST_IDLE, i2c_port_pkg::ST_IGNORE:
          oe_d = 1'b0;
        default:
          state_d = i2c_port_pkg::ST_IDLE;
      endcase
  end

  // The pointer has no reset value, so its content is undefined until loaded.
  always_ff @(posedge clk)
  begin
    if (ce)
      ptr_q <= ptr_d;
  end

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      state_q   <= i2c_port_pkg::ST_IDLE;
      cnt_q     <= 4'h0;
      sh_q      <= 8'h00;
      tx_q      <= 8'h00;
      oe_q      <= 1'b0;
      rw_q      <= 1'b0;
      mack_q    <= 1'b0;
      wr_en_q   <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
      sda_o_q   <= 1'b0;
    end
    else if (ce)
    begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      sh_q      <= sh_d;
      tx_q      <= tx_d;
      oe_q      <= oe_d;
      rw_q      <= rw_d;
      mack_q    <= mack_d;
      wr_en_q   <= wr_en_d;
      wr_addr_q <= wr_addr_d;
      wr_data_q <= wr_data_d;
      sda_o_q   <= 1'b0;
    end
  end

  // Only the data line is ever driven, and only low: the port stays a slave.
  assign sda_o  = sda_o_q;
  assign sda_oe = oe_q;

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  reg_bank #(
    .REVISION   (REVISION),
    .IDENTIFIER (IDENTIFIER)
  ) u_regs (
    .clk                 (clk),
    .rst_n               (rst_sync_n),
    .ce                  (ce),
    .wr_en               (wr_en_q),
    .wr_addr             (wr_addr_q),
    .wr_data             (wr_data_q),
    .rd_addr             (ptr_q),
    .rd_data             (rd_data),
    .fault_code          (fault_code),
    .frame_lock_state    (frame_lock_state),
    .aux_byte_count_low  (aux_byte_count_low),
    .aux_byte_count_high (aux_byte_count_high),
    .frame_header_high   (frame_header_high),
    .frame_header_middle (frame_header_middle),
    .ctrl_q              (ctrl),
    .software_restart_q  (software_restart)
  );

  assign clock_synth_control_low   = ctrl[0];
  assign clock_synth_multiplier    = ctrl[1];
  assign clock_synth_input_divider = ctrl[2];
  assign request_line_polarity     = ctrl[3];
  assign input_clock_polarity      = ctrl[4];
  assign playback_control          = ctrl[5];
  assign output_silence            = ctrl[6];
  assign command_irq               = ctrl[7];
  assign request_line_enable       = ctrl[8];

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  slave_only_a: assert property (oe_q |-> state_q != i2c_port_pkg::ST_IDLE && !sda_o_q)
    else $error("Data driven outside a transfer");
  start_seen_a: assert property (start_det && !stop_det |=> state_q == i2c_port_pkg::ST_ADDR && !oe_q)
    else $error("Start not taken");
  stop_idle_a: assert property (stop_det |=> state_q == i2c_port_pkg::ST_IDLE && !oe_q)
    else $error("Stop did not end transfer");
  ack_drive_a: assert property (state_q == i2c_port_pkg::ST_SUB_ACK |-> oe_q)
    else $error("Sub-address not acknowledged");
  rise_sample_a: assert property (scl_rise && !start_det && !stop_det
    && state_q == i2c_port_pkg::ST_SUB |=> sh_q[0] == $past(sda_i))
    else $error("Data not sampled on rising clock");
  addr_match_a: assert property ($rose(state_q == i2c_port_pkg::ST_ADDR_ACK)
    |-> $past(sh_q[7:1]) == DEV_ADDR && oe_q)
    else $error("Acknowledge without address match");
  sub_load_a: assert property ($rose(state_q == i2c_port_pkg::ST_SUB_ACK)
    |-> ptr_q == $past(sh_q))
    else $error("Sub-address not loaded");
  write_step_a: assert property (wr_en_q |-> ptr_q == wr_addr_q + 8'h01
    && state_q == i2c_port_pkg::ST_WR_ACK)
    else $error("Write did not advance pointer");
  read_step_a: assert property (state_q == i2c_port_pkg::ST_RD && scl_fall && cnt_q == 4'h7
    && !start_det && !stop_det |=> ptr_q == $past(ptr_q) + 8'h01 && !oe_q)
    else $error("Read did not advance pointer");
  read_nack_a: assert property (state_q == i2c_port_pkg::ST_RD_ACK && scl_fall && !mack_q
    && !start_det && !stop_det |=> state_q == i2c_port_pkg::ST_IGNORE)
    else $error("Nack did not end read");
  mismatch_quiet_a: assert property (state_q == i2c_port_pkg::ST_IGNORE |-> !oe_q)
    else $error("Data driven after mismatch");

  write_cov_c: cover property (wr_en_q);
  read_cov_c: cover property (state_q == i2c_port_pkg::ST_RD_ACK && scl_fall && mack_q);
  restart_cov_c: cover property (state_q == i2c_port_pkg::ST_WR && start_det);
  mismatch_cov_c: cover property (state_q == i2c_port_pkg::ST_IGNORE);
endmodule
`default_nettype wire

// *** dv/bus_master_model.sv ***
// Behavioural two-wire bus master that drives the register port.
// Assumes the bench resolves the open-drain data line with a pull-up.
`default_nettype none
module bus_master_model (
  // Clock
  input  wire logic clk,
  // Bus lines
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // A third of a bit time; every change lands just after a clock edge.
  task automatic q();
    repeat (4) @(posedge clk);
    #1;
  endtask

  // Also serves as a repeated start when entered with the clock low.
  task automatic start_c();
    sda_low = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b1;
    q();
    scl = 1'b0;
    q();
  endtask

  task automatic stop_c();
    sda_low = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b0;
    q();
  endtask

  // Whole bytes only, most significant bit first.
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      sda_low = ~b[i];
      q();
      scl = 1'b1;
      q();
      scl = 1'b0;
      q();
    end
    sda_low = 1'b0;
    q();
    scl = 1'b1;
    q();
    ack = sda_line;
    scl = 1'b0;
    q();
  endtask

  task automatic recv_byte(output logic [7:0] b, input logic ack_me);
    for (int i = 7; i >= 0; i--)
    begin
      q();
      scl = 1'b1;
      q();
      b[i] = sda_line;
      scl = 1'b0;
      q();
    end
    sda_low = ack_me;
    q();
    scl = 1'b1;
    q();
    scl = 1'b0;
    q();
    // Release the ack a third before anything else moves the line.
    sda_low = 1'b0;
    q();
  endtask
endmodule
`default_nettype wire

// *** dv/tb_i2c_slave_register_port.sv ***
// Self-checking bench for the two-wire register port.
// Assumes the bus master model is compiled before this file.
`default_nettype none
`include "i2c_port_params.svh"
module tb_i2c_slave_register_port;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] REV   = 8'h11;
  // Arbitrary value, not tied to any real part.
  localparam logic [7:0] IDN   = 8'h2d;
  localparam int         LIMIT = 20000;

  logic       clk, rst_n, ce, scl_i, sda_i, sda_o, sda_oe, m_low, software_restart;
  logic [7:0] fault_code, frame_lock_state, aux_byte_count_low, aux_byte_count_high;
  logic [7:0] frame_header_high, frame_header_middle, clock_synth_control_low;
  logic [7:0] clock_synth_multiplier, clock_synth_input_divider, request_line_polarity;
  logic [7:0] input_clock_polarity, playback_control, output_silence, command_irq;
  logic [7:0] request_line_enable;
  int         miscompares, comparisons, cycles, pulses;

  // Open-drain data line with pull-up.
  assign sda_i = (m_low | sda_oe) ? 1'b0 : 1'b1;

  i2c_slave_register_port #(.REVISION(REV), .IDENTIFIER(IDN)) DUT (
    .clk, .rst_n, .ce, .scl_i, .sda_i, .sda_o, .sda_oe,
    .fault_code, .frame_lock_state, .aux_byte_count_low, .aux_byte_count_high,
    .frame_header_high, .frame_header_middle, .clock_synth_control_low,
    .clock_synth_multiplier, .clock_synth_input_divider, .request_line_polarity,
    .input_clock_polarity, .playback_control, .output_silence, .command_irq,
    .request_line_enable, .software_restart
  );

  bus_master_model master (.clk(clk), .sda_line(sda_i), .scl(scl_i), .sda_low(m_low));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (software_restart === 1'b1)
      pulses++;
    if (cycles == LIMIT)
    begin
      miscompares++;
      conclude();
    end
  end

  task automatic conclude();
    $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask

  task automatic put(input logic [7:0] b, input logic exp_ack);
    logic a;
    master.send_byte(b, a);
    chk("ack", {7'h00, a}, {7'h00, exp_ack});
  endtask

  // Callers keep every byte inside documented, writable offsets.
  task automatic wr_seq(input logic [7:0] sub, input logic [7:0] d[$]);
    master.start_c();
    put(8'h86, 1'b0);
    put(sub, 1'b0);
    foreach (d[i])
      put(d[i], 1'b0);
    master.stop_c();
  endtask

  // Current-address read; the master withholds its ack on the last byte.
  task automatic rd_cur(input logic [7:0] e[$]);
    logic [7:0] b;
    master.start_c();
    put(8'h87, 1'b0);
    foreach (e[i])
    begin
      master.recv_byte(b, i < e.size() - 1);
      chk("read byte", b, e[i]);
    end
    master.stop_c();
  endtask

  task automatic rd_at(input logic [7:0] sub, input logic [7:0] e[$]);
    master.start_c();
    put(8'h86, 1'b0);
    put(sub, 1'b0);
    rd_cur(e);
  endtask

  task automatic t_reset();
    chk("synth low", clock_synth_control_low, `RST_SYNTH_LOW);
    chk("playback", playback_control, `RST_PLAYBACK);
    chk("clk pol", input_clock_polarity, `RST_CLK_POL);
    chk("synth mult", clock_synth_multiplier, `RST_SYNTH_MULT);
    chk("synth div", clock_synth_input_divider, `RST_SYNTH_DIV);
    chk("request_line_polarity", request_line_polarity, `RST_REQUEST_LINE_POLARITY);
    chk("cmd irq", command_irq, `RST_CMD_IRQ);
    chk("req en", request_line_enable, `RST_REQ_EN);
    chk("data out", {7'h00, sda_o}, 8'h00);
    chk("data drive", {7'h00, sda_oe}, 8'h00);
    rd_at(`OFS_SYNTH_LOW, '{`RST_SYNTH_LOW, `RST_SYNTH_MULT, `RST_SYNTH_DIV});
    rd_at(`OFS_REVISION, '{REV, IDN});
    $display("test reset values done");
  endtask

  task automatic t_write();
    wr_seq(`OFS_SYNTH_LOW, '{8'h5a, 8'hc3});
    chk("synth low", clock_synth_control_low, 8'h5a);
    chk("synth mult", clock_synth_multiplier, 8'hc3);
    rd_cur('{`RST_SYNTH_DIV});
    rd_at(`OFS_FAULT, '{fault_code});
    $display("test multibyte write done");
  endtask

  task automatic t_status();
    rd_at(`OFS_LOCK, '{frame_lock_state, aux_byte_count_low, aux_byte_count_high,
      frame_header_high, frame_header_middle});
    $display("test status read done");
  endtask

  task automatic t_restart();
    pulses = 0;
    wr_seq(`OFS_RESTART, '{8'h01});
    chk("restart pulses", pulses[7:0], 8'h01);
    $display("test restart pulse done");
  endtask

  // A foreign address must be ignored, data line released, nothing stored.
  task automatic t_mismatch();
    master.start_c();
    put(8'h88, 1'b1);
    put(`OFS_SILENCE, 1'b1);
    put(8'hff, 1'b1);
    master.stop_c();
    chk("silence", output_silence, `RST_SILENCE);
    wr_seq(`OFS_PLAYBACK, '{8'h96, 8'h3c});
    chk("silence", output_silence, 8'h3c);
    chk("playback", playback_control, 8'h96);
    $display("test address mismatch done");
  endtask

  initial
  begin
    rst_n = 1'b0;
    ce = 1'b1;
    fault_code = 8'h3e;
    frame_lock_state = 8'h81;
    aux_byte_count_low = 8'h42;
    aux_byte_count_high = 8'h24;
    frame_header_high = 8'hc7;
    frame_header_middle = 8'h7c;
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    t_reset();
    t_write();
    t_status();
    t_restart();
    t_mismatch();
    conclude();
  end
endmodule
`default_nettype wire
